/* File: icu_top.v */
// Purpose: Prioritized vectored interrupt controller with eight event channels.
// Assumes: Classic Wishbone slave, one 20 MHz clock, CPU answers by handshake.
// Notes: Sources 0-5 are compare channels, 6-7 the fast external inputs.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "icu_defs.vh"
// Contract
// - Respond within 78 to 187.5 ns.
// - Serve by vectored branch or transfer channel.
// - Transfer takes one CPU cycle, no branch.
// - Move byte or word, bump one pointer.
// - Decrement counter unless continuous mode.
// - Counter zero raises the source's vectored interrupt.
// - Eight channels, own pointers and counters.
// - Per-source request, enable, priority register.
// - Sixteen priority levels drive arbitration.
// - Preempt only for strictly higher level.
// - Each source has its own trap vector.
// - Software trap branches to its vector.
// - Fast inputs: rising, falling or both edges.
// - Fast input source selectable from peripherals.
// - Compare 0-5 use traps 10h-15h, vectors 40h up.
module icu_top (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [5:0] cc_req_i,
  input wire [1:0] fast_pin_i,
  input wire can_receive_line_i,
  input wire i2c_scl_i,
  input wire trap_req_i,
  input wire [7:0] trap_num_i,
  output wire irq_req_o,
  output reg [23:0] irq_vector_o,
  output reg [7:0] irq_trap_o,
  output reg [3:0] irq_level_o,
  input wire irq_ack_i,
  input wire irq_ret_i,
  output wire xfer_req_o,
  output reg [23:0] xfer_src_o,
  output reg [23:0] xfer_dst_o,
  output reg xfer_word_o,
  input wire xfer_done_i,
  output wire sys_irq_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_ARB = 2'b01;
  localparam ST_INT = 2'b10;
  localparam ST_XFER = 2'b11;

  reg [1:0] state;
  reg [3:0] lvl [0:7];
  reg [2:0] chn [0:7];
  reg [7:0] chen;
  reg [7:0] en;
  reg [7:0] req;
  reg [23:0] src_ptr [0:7];
  reg [23:0] dst_ptr [0:7];
  reg [7:0] cnt [0:7];
  reg [7:0] word;
  reg [7:0] incdst;
  reg [7:0] cont;
  reg [7:0] fast_cfg;
  reg [7:0] evt_stat;
  reg [7:0] evt_en;
  reg [15:0] in_svc;
  reg trap_pend;
  reg [7:0] trap_num_q;
  reg svc_sw;
  reg [2:0] svc_idx;
  reg [3:0] cur_lvl;
  reg [31:0] rd_data;
  wire [1:0] fast_edge;
  wire [7:0] src_pulse;
  wire [7:0] pend;
  wire [31:0] lvl_flat;
  wire win;
  wire [2:0] win_idx;
  wire [3:0] win_lvl;
  wire [2:0] win_ch;
  wire win_xfer;
  wire [2:0] svc_ch;
  wire [7:0] step;
  wire wr;
  wire ack_hw;
  wire done;
  wire [31:0] m;
  integer i;
  integer j;

  // Fast external inputs; input 0 may take the bus receive line, 1 the serial clock.
  fast_edge_input u_fast0 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(fast_cfg[1:0]),
    .alt_sel_i(fast_cfg[2]),
    .pin_i(fast_pin_i[0]),
    .alt_i(can_receive_line_i),
    .edge_o(fast_edge[0])
  );
  fast_edge_input u_fast1 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(fast_cfg[5:4]),
    .alt_sel_i(fast_cfg[6]),
    .pin_i(fast_pin_i[1]),
    .alt_i(i2c_scl_i),
    .edge_o(fast_edge[1])
  );

  assign src_pulse = {fast_edge, cc_req_i};
  assign pend = req & en;

  // Levels packed for the arbiter.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_lvl
      assign lvl_flat[4*g +: 4] = lvl[g];
    end
  endgenerate

  priority_arbiter u_arb (
    .pend_i(pend),
    .lvl_i(lvl_flat),
    .cur_lvl_i(cur_lvl),
    .busy_i(|in_svc),
    .win_o(win),
    .idx_o(win_idx),
    .win_lvl_o(win_lvl)
  );

  // A source with its channel on and counts left is moved, not branched.
  assign win_ch = chn[win_idx];
  assign win_xfer = chen[win_idx] && (cont[win_ch] || cnt[win_ch] != 8'h00);
  assign svc_ch = chn[svc_idx];
  assign step = word[svc_ch] ? 8'h02 : 8'h01;

  // Level in service is the highest bit of the nesting mask.
  always @*
  begin
    cur_lvl = 4'h0;
    for (j = 0; j < 16; j = j + 1)
      if (in_svc[j])
        cur_lvl = j[3:0];
  end

  assign irq_req_o = (state == ST_INT);
  assign xfer_req_o = (state == ST_XFER);
  assign ack_hw = (state == ST_INT) && irq_ack_i && !svc_sw;
  assign done = (state == ST_XFER) && xfer_done_i;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign sys_irq_o = |(evt_stat & evt_en);

  // Byte lane merge for writes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] sel;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Write word with unselected lanes kept, so a partial write leaves other fields alone.
  assign m = merge(rd_data, wb_dat_i, wb_sel_i);

  // Trap number of a source.
  function [7:0] trap_of;
    input [2:0] idx;
    begin
      case (idx)
        3'h6: trap_of = `ICU_FAST0_TRAP;
        3'h7: trap_of = `ICU_FAST1_TRAP;
        default: trap_of = `ICU_CC_TRAP_BASE + {5'h00, idx};
      endcase
    end
  endfunction

  // Wishbone answer one cycle after the strobe; unmapped reads give zero.
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // Read multiplexer.
  always @*
  begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i[7:5] == 3'b000)
      rd_data = {22'h000000, req[wb_adr_i[4:2]], en[wb_adr_i[4:2]],
                 chen[wb_adr_i[4:2]], chn[wb_adr_i[4:2]], lvl[wb_adr_i[4:2]]};
    else if (wb_adr_i[7])
    begin
      case (wb_adr_i[3:2])
        `ICU_CH_SRC: rd_data = {8'h00, src_ptr[wb_adr_i[6:4]]};
        `ICU_CH_DST: rd_data = {8'h00, dst_ptr[wb_adr_i[6:4]]};
        `ICU_CH_CTL: rd_data = {21'h000000, cont[wb_adr_i[6:4]], incdst[wb_adr_i[6:4]],
                                word[wb_adr_i[6:4]], cnt[wb_adr_i[6:4]]};
        default: rd_data = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (wb_adr_i)
        `ICU_FAST_CFG: rd_data = {24'h000000, fast_cfg};
        `ICU_SVC_STAT: rd_data = {9'h000, state, trap_pend, cur_lvl, in_svc};
        `ICU_EVT_STAT: rd_data = {24'h000000, evt_stat};
        `ICU_EVT_EN: rd_data = {24'h000000, evt_en};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Source and channel registers; a hardware set always beats a clear.
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        lvl[i] <= 4'h0;
        chn[i] <= 3'h0;
        src_ptr[i] <= 24'h000000;
        dst_ptr[i] <= 24'h000000;
        cnt[i] <= 8'h00;
      end
      chen <= 8'h00;
      en <= 8'h00;
      req <= 8'h00;
      word <= 8'h00;
      incdst <= 8'h00;
      cont <= 8'h00;
      fast_cfg <= 8'h00;
      evt_stat <= 8'h00;
      evt_en <= 8'h00;
    end
    else
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        if (wr && wb_adr_i[7:5] == 3'b000 && wb_adr_i[4:2] == i[2:0])
        begin
          lvl[i] <= m[`ICU_LVL_LSB +: 4];
          chn[i] <= m[`ICU_CHN_LSB +: 3];
          chen[i] <= m[`ICU_CHEN_BIT];
          en[i] <= m[`ICU_EN_BIT];
          req[i] <= m[`ICU_REQ_BIT];
        end
        if (wr && wb_adr_i[7] && wb_adr_i[6:4] == i[2:0])
        begin
          if (wb_adr_i[3:2] == `ICU_CH_SRC)
            src_ptr[i] <= m[23:0];
          if (wb_adr_i[3:2] == `ICU_CH_DST)
            dst_ptr[i] <= m[23:0];
          if (wb_adr_i[3:2] == `ICU_CH_CTL)
          begin
            cnt[i] <= m[`ICU_CNT_LSB +: 8];
            word[i] <= m[`ICU_WORD_BIT];
            incdst[i] <= m[`ICU_INCDST_BIT];
            cont[i] <= m[`ICU_CONT_BIT];
          end
        end
        // Taken vectored request clears its flag.
        if (ack_hw && svc_idx == i[2:0])
          req[i] <= 1'b0;
        // A move clears the flag unless the count just ran out.
        if (done && svc_idx == i[2:0] && (cont[svc_ch] || cnt[svc_ch] != 8'h01))
          req[i] <= 1'b0;
        if (src_pulse[i])
          req[i] <= 1'b1;
      end
      // One move per grant, then one pointer steps by the item size.
      if (done)
      begin
        if (incdst[svc_ch])
          dst_ptr[svc_ch] <= dst_ptr[svc_ch] + {16'h0000, step};
        else
          src_ptr[svc_ch] <= src_ptr[svc_ch] + {16'h0000, step};
        if (!cont[svc_ch])
          cnt[svc_ch] <= cnt[svc_ch] - 8'h01;
      end
      if (wr && wb_adr_i == `ICU_FAST_CFG)
        fast_cfg <= m[7:0];
      if (wr && wb_adr_i == `ICU_EVT_EN)
        evt_en <= m[7:0];
      // Channel exhaustion events are sticky; the set wins over the clear.
      for (i = 0; i < 8; i = i + 1)
        if (done && svc_ch == i[2:0] && !cont[i] && cnt[i] == 8'h01)
          evt_stat[i] <= 1'b1;
        else if (wr && wb_adr_i == `ICU_EVT_CLR && wb_sel_i[0] && wb_dat_i[i])
          evt_stat[i] <= 1'b0;
    end
  end

  // Service sequencer: one cycle to latch the winner, then present it.
  // Flag set at edge 0 shows as a request after edge 2, which is inside the
  // response window; a faster path would need an unregistered vector.
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_IDLE;
      in_svc <= 16'h0000;
      trap_pend <= 1'b0;
      trap_num_q <= 8'h00;
      svc_sw <= 1'b0;
      svc_idx <= 3'h0;
      irq_vector_o <= 24'h000000;
      irq_trap_o <= 8'h00;
      irq_level_o <= 4'h0;
      xfer_src_o <= 24'h000000;
      xfer_dst_o <= 24'h000000;
      xfer_word_o <= 1'b0;
    end
    else
    begin
      if (irq_ret_i)
        in_svc[cur_lvl] <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (trap_pend || win)
            state <= ST_ARB;
        end
        ST_ARB:
        begin
          if (trap_pend)
          begin
            svc_sw <= 1'b1;
            irq_trap_o <= trap_num_q;
            irq_vector_o <= {14'h0000, trap_num_q, 2'b00};
            irq_level_o <= cur_lvl;
            state <= ST_INT;
          end
          else if (win && win_xfer)
          begin
            svc_sw <= 1'b0;
            svc_idx <= win_idx;
            xfer_src_o <= src_ptr[win_ch];
            xfer_dst_o <= dst_ptr[win_ch];
            xfer_word_o <= word[win_ch];
            state <= ST_XFER;
          end
          else if (win)
          begin
            svc_sw <= 1'b0;
            svc_idx <= win_idx;
            irq_trap_o <= trap_of(win_idx);
            irq_vector_o <= {14'h0000, trap_of(win_idx), 2'b00};
            irq_level_o <= win_lvl;
            state <= ST_INT;
          end
          else
            state <= ST_IDLE;
        end
        ST_INT:
        begin
          if (irq_ack_i)
          begin
            if (!svc_sw)
              in_svc[irq_level_o] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_XFER:
        begin
          // The CPU lends one cycle and carries on; nothing is nested.
          if (xfer_done_i)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_INT && irq_ack_i && svc_sw)
        trap_pend <= 1'b0;
      // A new trap request wins over the clear of the previous one.
      if (trap_req_i)
      begin
        trap_pend <= 1'b1;
        trap_num_q <= trap_num_i;
      end
    end
  end
endmodule // icu_top
`default_nettype wire

/* File: icu_defs.vh */
// Purpose: Constants of the prioritized interrupt and event transfer block.
// Assumes: 20 MHz system clock, Wishbone register word per 32-bit address.
// Notes: Offsets are byte addresses on an 8-bit Wishbone address.
`ifndef ICU_DEFS_VH
`define ICU_DEFS_VH

// Source and channel counts.
`define ICU_NSRC 8
`define ICU_NCH 8

// Register map.
`define ICU_SRC_BASE 8'h00
`define ICU_FAST_CFG 8'h20
`define ICU_SVC_STAT 8'h24
`define ICU_EVT_STAT 8'h28
`define ICU_EVT_EN 8'h2c
`define ICU_EVT_CLR 8'h30
`define ICU_CH_BASE 8'h80
`define ICU_CH_SRC 2'h0
`define ICU_CH_DST 2'h1
`define ICU_CH_CTL 2'h2

// Source control fields.
`define ICU_LVL_LSB 0
`define ICU_CHN_LSB 4
`define ICU_CHEN_BIT 7
`define ICU_EN_BIT 8
`define ICU_REQ_BIT 9

// Channel control fields.
`define ICU_CNT_LSB 0
`define ICU_WORD_BIT 8
`define ICU_INCDST_BIT 9
`define ICU_CONT_BIT 10

// Trap numbers; compare channel n uses base plus n, vector is trap times four.
`define ICU_CC_TRAP_BASE 8'h10
`define ICU_FAST0_TRAP 8'h48
`define ICU_FAST1_TRAP 8'h49

// Response time window in picoseconds and the derived cycle counts.
`define ICU_CLK_PS 50000
`define ICU_RESP_MIN_PS 78000
`define ICU_RESP_MAX_PS 187500
`define ICU_RESP_MIN_CYC ((`ICU_RESP_MIN_PS + `ICU_CLK_PS - 1) / `ICU_CLK_PS)
`define ICU_RESP_MAX_CYC (`ICU_RESP_MAX_PS / `ICU_CLK_PS)

// Reset value of every control register.
`define ICU_RST_VAL 32'h0000_0000

`endif

/* File: fast_edge_input.v */
// Purpose: Edge detector of one fast external interrupt input.
// Assumes: Pin and alternate signal are synchronous to the clock.
// Notes: Mode 1 rising, 2 falling, 3 both, 0 off.
`timescale 1ns/100ps
`default_nettype none
module fast_edge_input (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [1:0] mode_i,
  input wire alt_sel_i,
  input wire pin_i,
  input wire alt_i,
  output wire edge_o
);
  reg prev;
  wire cur;

  // Source is the pin or a peripheral line such as a bus receive input.
  assign cur = alt_sel_i ? alt_i : pin_i;

  // Previous level for edge comparison.
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prev <= 1'b0;
    else
      prev <= cur;
  end

  // Pulse for the selected edge type.
  assign edge_o = (mode_i[0] & cur & ~prev) | (mode_i[1] & ~cur & prev);
endmodule // fast_edge_input
`default_nettype wire

/* File: priority_arbiter.v */
// Purpose: Picks the highest pending level above the level in service.
// Assumes: Levels packed four bits per source, source 0 in the low bits.
// Notes: Equal levels resolve to the lowest source index.
`timescale 1ns/100ps
`default_nettype none
module priority_arbiter (
  input wire [7:0] pend_i,
  input wire [31:0] lvl_i,
  input wire [3:0] cur_lvl_i,
  input wire busy_i,
  output reg win_o,
  output reg [2:0] idx_o,
  output reg [3:0] win_lvl_o
);
  integer i;

  // Strict compares keep the earliest index on a tie.
  always @*
  begin
    win_o = 1'b0;
    idx_o = 3'h0;
    win_lvl_o = 4'h0;
    for (i = 0; i < 8; i = i + 1)
      if (pend_i[i] && (!busy_i || lvl_i[4*i +: 4] > cur_lvl_i) &&
          (!win_o || lvl_i[4*i +: 4] > win_lvl_o))
      begin
        win_o = 1'b1;
        idx_o = i[2:0];
        win_lvl_o = lvl_i[4*i +: 4];
      end
  end
endmodule // priority_arbiter
`default_nettype wire

/* File: icu_chk.sv */
// Purpose: Port-level checks of the interrupt and event transfer block.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Bound into icu_top; watches only its ports.
`timescale 1ns/100ps
`default_nettype none
module icu_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic irq_req_o,
  input wire logic [23:0] irq_vector_o,
  input wire logic [7:0] irq_trap_o,
  input wire logic [3:0] irq_level_o,
  input wire logic irq_ack_i,
  input wire logic xfer_req_o,
  input wire logic [23:0] xfer_src_o,
  input wire logic [23:0] xfer_dst_o,
  input wire logic xfer_word_o,
  input wire logic xfer_done_i
);
  // All checks share the one clock and the one reset.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // Bus answers once, one cycle after the request is taken.
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack missing");
  property p_wb_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack too long");

  // A presented service must not change under the CPU before it is taken.
  property p_irq_hold;
    irq_req_o && !irq_ack_i |=> irq_req_o && $stable(irq_trap_o) && $stable(irq_level_o);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("service withdrawn");
  property p_vec;
    irq_req_o |-> irq_vector_o == {14'h0000, irq_trap_o, 2'b00};
  endproperty
  a_vec: assert property (p_vec) else $error("vector not trap times four");
  property p_irq_drop;
    irq_req_o && irq_ack_i |=> !irq_req_o;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request after ack");

  // The stolen cycle keeps its addresses and size until done.
  property p_xfer_hold;
    xfer_req_o && !xfer_done_i |=> xfer_req_o && $stable(xfer_src_o) && $stable(xfer_dst_o)
      && $stable(xfer_word_o);
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("transfer changed");
  property p_xfer_drop;
    xfer_req_o && xfer_done_i |=> !xfer_req_o;
  endproperty
  a_xfer_drop: assert property (p_xfer_drop) else $error("transfer after done");
  property p_excl;
    xfer_req_o |-> !irq_req_o;
  endproperty
  a_excl: assert property (p_excl) else $error("two services at once");

  // Main scenarios seen.
  c_irq: cover property (irq_req_o && irq_ack_i);
  c_xfer: cover property (xfer_req_o && xfer_done_i);
  c_word: cover property (xfer_req_o && xfer_word_o);
endmodule // icu_chk
bind icu_top icu_chk u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_req_o(irq_req_o),
  .irq_vector_o(irq_vector_o), .irq_trap_o(irq_trap_o), .irq_level_o(irq_level_o),
  .irq_ack_i(irq_ack_i), .xfer_req_o(xfer_req_o), .xfer_src_o(xfer_src_o),
  .xfer_dst_o(xfer_dst_o), .xfer_word_o(xfer_word_o), .xfer_done_i(xfer_done_i));
`default_nettype wire

/* File: cpu_model.sv */
// Purpose: CPU core side: takes vectored services and performs stolen cycles.
// Assumes: Same clock as the block; answer delay set by the bench.
// Notes: Never returns from service by itself; the bench does that.
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] lat_i,
  input wire logic irq_req_i,
  input wire logic xfer_req_i,
  output logic irq_ack_o,
  output logic xfer_done_o
);
  logic [3:0] cnt;
  // Waits lat_i cycles on a standing request, then answers for one cycle.
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt <= 4'h0;
      irq_ack_o <= 1'b0;
      xfer_done_o <= 1'b0;
    end
    else if (irq_ack_o || xfer_done_o)
    begin
      irq_ack_o <= 1'b0;
      xfer_done_o <= 1'b0;
      cnt <= 4'h0;
    end
    else if ((irq_req_i || xfer_req_i) && cnt == lat_i)
    begin
      irq_ack_o <= irq_req_i;
      xfer_done_o <= xfer_req_i;
    end
    else
      cnt <= (irq_req_i || xfer_req_i) ? cnt + 4'h1 : 4'h0;
  end
endmodule // cpu_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench of the interrupt and event transfer block.
// Assumes: 20 MHz clock, classic Wishbone master tasks, CPU model as partner.
// Notes: Services are measured from the edge that takes the source pulse.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, trap_num_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf, lat = 4'h0, irq_level_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic [5:0] cc_req_i = 6'h00;
  logic [1:0] fast_pin_i = 2'h0;
  logic can_rx = 1'b0, scl = 1'b0, trap_req_i = 1'b0, irq_ret_i = 1'b0;
  logic wb_ack_o, irq_req_o, irq_ack_i, xfer_req_o, xfer_word_o, xfer_done_i, sys_irq_o;
  logic [23:0] irq_vector_o, xfer_src_o, xfer_dst_o;
  logic [7:0] irq_trap_o;
  int n_fail = 0, checks = 0, i;

  // Clock at 50 ns period.
  always #25 clk_sys_i = ~clk_sys_i;

  icu_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc_req_i(cc_req_i),
    .fast_pin_i(fast_pin_i), .can_receive_line_i(can_rx), .i2c_scl_i(scl),
    .trap_req_i(trap_req_i), .trap_num_i(trap_num_i), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_trap_o(irq_trap_o), .irq_level_o(irq_level_o),
    .irq_ack_i(irq_ack_i), .irq_ret_i(irq_ret_i), .xfer_req_o(xfer_req_o),
    .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o), .xfer_word_o(xfer_word_o),
    .xfer_done_i(xfer_done_i), .sys_irq_o(sys_irq_o));
  cpu_model cpu (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .lat_i(lat),
    .irq_req_i(irq_req_o), .xfer_req_i(xfer_req_o), .irq_ack_o(irq_ack_i),
    .xfer_done_o(xfer_done_i));

  task end_of_test;
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle; held until ack is sampled, released after it.
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task pulse(input logic [5:0] m);
    @(posedge clk_sys_i) cc_req_i <= m;
    @(posedge clk_sys_i) cc_req_i <= 6'h00;
  endtask

  task ret;
    @(posedge clk_sys_i) irq_ret_i <= 1'b1;
    @(posedge clk_sys_i) irq_ret_i <= 1'b0;
  endtask

  // Waits for a service, checks what it presents, lets the CPU take it.
  task svc(input logic [7:0] t, input logic [3:0] l, input bit rt, input bit cl);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (irq_req_o !== 1'b1 && n < 16);
    if (cl)
      chk(32'(n - 1 >= 2 && n - 1 <= 3), 32'h1);
    chk({irq_trap_o, irq_vector_o}, {t, 14'h0, t, 2'b00});
    chk({28'h0, irq_level_o}, {28'h0, l});
    while (irq_ack_i !== 1'b1) @(posedge clk_sys_i);
    if (rt)
      ret();
  endtask

  task quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) @(posedge clk_sys_i) s = s | (irq_req_o !== 1'b0);
    chk({31'h0, s}, 32'h0);
  endtask

  task xf(input logic [23:0] s, input logic [23:0] d, input logic w);
    i = 0;
    do @(posedge clk_sys_i); while (xfer_req_o !== 1'b1 && ++i < 16);
    chk({xfer_word_o, xfer_src_o, 7'h0}, {w, s, 7'h0});
    chk({8'h0, xfer_dst_o}, {8'h0, d});
    while (xfer_done_i !== 1'b1) @(posedge clk_sys_i);
  endtask

  // A hang ends the run as a failure.
  initial
  begin
    #(50 * 10000);
    n_fail++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h24, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'(4 * i), 32'h200 | (i << 4) | (15 - i));
      rdc(8'(4 * i), 32'h200 | (i << 4) | (15 - i));
    end
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      lat <= 4'(k);
      wb(1'b1, 8'(4 * k), 32'h101);
      pulse(6'(1 << k));
      svc(8'h10 + 8'(k), 4'h1, 1'b1, 1'b1);
      wb(1'b1, 8'(4 * k), 32'h0);
    end
    wb(1'b1, 8'h0c, 32'h105);
    wb(1'b1, 8'h08, 32'h105);
    wb(1'b1, 8'h04, 32'h107);
    pulse(6'h08);
    svc(8'h13, 4'h5, 1'b0, 1'b1);
    rdc(8'h24, 32'h0005_0020);
    pulse(6'h04);
    quiet(10);
    pulse(6'h02);
    svc(8'h11, 4'h7, 1'b1, 1'b1);
    quiet(8);
    ret();
    svc(8'h12, 4'h5, 1'b1, 1'b0);
    wb(1'b1, 8'h10, 32'h103);
    wb(1'b1, 8'h08, 32'h103);
    pulse(6'h14);
    svc(8'h12, 4'h3, 1'b1, 1'b1);
    svc(8'h14, 4'h3, 1'b1, 1'b0);
    @(posedge clk_sys_i) {trap_req_i, trap_num_i} <= {1'b1, 8'h2a};
    @(posedge clk_sys_i) trap_req_i <= 1'b0;
    svc(8'h2a, 4'h0, 1'b0, 1'b1);
    wb(1'b1, 8'h18, 32'h101);
    for (i = 1; i < 4; i++)
    begin
      wb(1'b1, 8'h20, 32'(i));
      @(posedge clk_sys_i) fast_pin_i[0] <= 1'b1;
      if (i != 2) svc(8'h48, 4'h1, 1'b1, 1'b0); else quiet(10);
      @(posedge clk_sys_i) fast_pin_i[0] <= 1'b0;
      if (i != 1) svc(8'h48, 4'h1, 1'b1, 1'b0); else quiet(10);
    end
    wb(1'b1, 8'h1c, 32'h101);
    wb(1'b1, 8'h20, 32'h75);
    @(posedge clk_sys_i) can_rx <= 1'b1;
    svc(8'h48, 4'h1, 1'b1, 1'b0);
    @(posedge clk_sys_i) scl <= 1'b1;
    svc(8'h49, 4'h1, 1'b1, 1'b0);
    wb(1'b1, 8'h90, 32'h100);
    wb(1'b1, 8'h94, 32'h200);
    wb(1'b1, 8'h98, 32'h102);
    wb(1'b1, 8'h14, 32'h192);
    pulse(6'h20);
    xf(24'h100, 24'h200, 1'b1);
    rdc(8'h90, 32'h102);
    rdc(8'h98, 32'h101);
    pulse(6'h20);
    xf(24'h102, 24'h200, 1'b1);
    svc(8'h15, 4'h2, 1'b1, 1'b0);
    rdc(8'h28, 32'h2);
    wb(1'b1, 8'h2c, 32'h2);
    chk({31'h0, sys_irq_o}, 32'h1);
    wb(1'b1, 8'h30, 32'h2);
    chk({31'h0, sys_irq_o}, 32'h0);
    wb(1'b1, 8'h98, 32'h600);
    pulse(6'h20);
    xf(24'h104, 24'h200, 1'b0);
    rdc(8'h94, 32'h201);
    rdc(8'h98, 32'h600);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
